// ===== rtl/fcp_pkg.sv
/*
 * shared constants and types for the flash configuration and
 * protection register block.
 * assumes nothing beyond a systemverilog-2012 compiler.
 */
package fcp_pkg;
    // ----------------------------------------
    // configuration register layout
    // ----------------------------------------
    localparam logic [7:0] CFG_RESET = 8'hff; // all defaults
    localparam int CFG_QUAD_BIT = 7; // 0 = four-line commands
    localparam int CFG_DUAL_BIT = 6; // 0 = two-line commands
    localparam int CFG_DTR_BIT = 5; // 0 = double rate
    localparam int CFG_HOLD_BIT = 4; // 1 = hold/reset on pin
    localparam int CFG_RSVD_BIT = 3; // reads as 1
    localparam int CFG_DRV_MSB = 2; // drive code 2:0
    localparam logic [2:0] DRV_90 = 3'h1;
    localparam logic [2:0] DRV_45 = 3'h3;
    localparam logic [2:0] DRV_20 = 3'h5;
    localparam logic [2:0] DRV_30 = 3'h7; // default
    // ----------------------------------------
    // protection mode and password layout
    // ----------------------------------------
    localparam logic [15:0] PROT_RESET = 16'hffff;
    localparam int PROT_PW_BIT = 2; // 0 = password mode
    localparam int PROT_SEC_BIT = 1; // 0 = no password
    localparam logic [63:0] PW_RESET = 64'hffff_ffff_ffff_ffff;
    localparam logic [63:0] PW_HIDDEN = 64'hffff_ffff_ffff_ffff;
    // ----------------------------------------
    // synchroniser depth and command set
    // ----------------------------------------
    localparam int SYNC_LEN = 3; // two sync flops plus edge flop
    typedef enum logic [1:0] {
        PROTO_SINGLE, PROTO_DUAL, PROTO_QUAD
    } fcp_proto_type;
    typedef enum logic [3:0] {
        CMD_WR_CFG, CMD_RD_CFG, CMD_RESCUE, CMD_RD_PROT,
        CMD_WR_PROT, CMD_RD_PW, CMD_WR_PW, CMD_RD_FRZ,
        CMD_WR_FRZ, CMD_UNLOCK, CMD_WR_NV, CMD_ER_NV,
        CMD_RD_NV, CMD_WR_VOL, CMD_RD_VOL, CMD_SW_RST
    } fcp_cmd_type;
endpackage

// ===== rtl/fcp_regs.sv
/*
 * configuration, protection-mode and freeze registers of a serial
 * flash, with sector lock bits, plus the serial-clock command port.
 * assumes the host presents one decoded command at a time on the
 * serial clock and waits for rsp_valid before the next one.
 */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// serial-clock side: command capture
// ----------------------------------------
module fcp_link
    import fcp_pkg::*;
#(
    parameter int IDX_W = 8
) (
    input wire logic sclk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire fcp_cmd_type cmd_op,
    input wire logic [IDX_W-1:0] cmd_idx,
    input wire logic [63:0] cmd_arg,
    output logic cmd_busy,
    output logic rsp_valid,
    output logic rsp_ok,
    output logic [63:0] rsp_data,
    output logic req_tog,
    output fcp_cmd_type held_op,
    output logic [IDX_W-1:0] held_idx,
    output logic [63:0] held_arg,
    input wire logic ack_tog,
    input wire logic ref_ok,
    input wire logic [63:0] ref_rsp
);
    typedef struct packed {
        logic [1:0] rs; // reset synchroniser
        logic [SYNC_LEN-1:0] ack_s; // ack toggle synchroniser
        logic req; // request toggle
        logic busy; // command in flight
        fcp_cmd_type op;
        logic [IDX_W-1:0] idx;
        logic [63:0] arg;
        logic rv; // answer pulse
        logic ok;
        logic [63:0] data;
    } fcp_link_type;

    fcp_link_type l_q, l_d;
    logic lrst; // reset as seen on this clock
    logic ack_edge; // reference side finished

    assign lrst = l_q.rs[1];
    assign ack_edge = l_q.ack_s[2] ^ l_q.ack_s[1];

    // next state; held fields stay put while busy so the other
    // domain can read them without its own synchroniser
    always_comb begin
        l_d = l_q;
        l_d.ack_s = {l_q.ack_s[1:0], ack_tog};
        l_d.rv = 1'b0;
        if (cmd_valid && !l_q.busy) begin
            l_d.op = cmd_op;
            l_d.idx = cmd_idx;
            l_d.arg = cmd_arg;
            l_d.req = ~l_q.req;
            l_d.busy = 1'b1;
        end
        if (l_q.busy && ack_edge) begin
            // answer is stable: reference side holds it until next req
            l_d.busy = 1'b0;
            l_d.rv = 1'b1;
            l_d.ok = ref_ok;
            l_d.data = ref_rsp;
        end
        if (lrst) begin
            l_d = '0;
        end
        l_d.rs = {l_q.rs[0], rst};
    end

    // single register stage for the whole link state
    always_ff @(posedge sclk) begin
        l_q <= l_d;
    end

    assign cmd_busy = l_q.busy;
    assign rsp_valid = l_q.rv;
    assign rsp_ok = l_q.ok;
    assign rsp_data = l_q.data;
    assign req_tog = l_q.req;
    assign held_op = l_q.op;
    assign held_idx = l_q.idx;
    assign held_arg = l_q.arg;

    // every accepted command is answered within a bounded time
    rsp_bound_a: assert property (@(posedge sclk) disable iff (lrst)
        (cmd_valid && !l_q.busy) |-> ##[4:40] l_q.rv)
        else $error("command not answered in time");
    // held command must not move under the other domain
    hold_stable_a: assert property (@(posedge sclk) disable iff (lrst)
        (l_q.busy && !ack_edge) |=> $stable(l_q.arg) && $stable(l_q.op))
        else $error("held command changed while busy");
endmodule

// ----------------------------------------
// reference-clock side: the registers
// ----------------------------------------
module fcp_regs
    import fcp_pkg::*;
#(
    parameter int SECTORS = 256,
    parameter int SUBS = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic data_line_three,
    input wire logic cmd_valid,
    input wire fcp_cmd_type cmd_op,
    input wire logic [$clog2(SECTORS)-1:0] cmd_idx,
    input wire logic [63:0] cmd_arg,
    output logic cmd_busy,
    output logic rsp_valid,
    output logic rsp_ok,
    output logic [63:0] rsp_data,
    output fcp_proto_type proto_mode,
    output logic dtr_en,
    output logic hold_rst_en,
    output logic [2:0] drive_code,
    output logic frz_bit,
    output logic pw_mode,
    output logic [SECTORS-1:0] sector_blocked,
    output logic [2*SUBS-1:0] edge_sub_lock
);
    localparam int IDX_W = $clog2(SECTORS);
    localparam int SUB_W = $clog2(SUBS);

    typedef struct packed {
        logic [1:0] pin_s; // reset pin synchroniser
        logic [SYNC_LEN-1:0] req_s; // request toggle synchroniser
        logic ack; // answer toggle
        logic [7:0] cfg; // stored configuration
        fcp_proto_type proto; // active settings below
        logic dtr;
        logic hold;
        logic [2:0] drv;
        logic [15:0] prot; // one-time mode register
        logic frz; // freeze bit
        logic [63:0] pw; // password
        logic [SECTORS-1:0] nv; // 0 = locked
        logic [SECTORS-1:0] vol; // 1 = locked
        logic [2*SUBS-1:0] sub; // edge subsector locks
        logic [SECTORS-1:0] blk; // combined write block
        logic ok;
        logic [63:0] rsp;
    } fcp_state_type;

    fcp_state_type s_q, s_d;
    logic req_tog; // from link side
    logic ack_tog; // back to link side
    fcp_cmd_type op; // held command fields
    logic [IDX_W-1:0] idx;
    logic [63:0] arg;
    logic go; // one command to run now
    logic pin_rst; // hardware reset via the pin
    logic pw_on; // password mode programmed
    logic [7:0] wcfg; // written config with fixed bits

    // four-line beats two-line when both are enabled
    function automatic fcp_proto_type proto_of(input logic [7:0] c);
        if (!c[CFG_QUAD_BIT]) begin
            return PROTO_QUAD;
        end else if (!c[CFG_DUAL_BIT]) begin
            return PROTO_DUAL;
        end
        return PROTO_SINGLE;
    endfunction

    // reserved drive codes are refused, old code kept
    function automatic logic drv_legal(input logic [2:0] c);
        return c == DRV_90 || c == DRV_45 || c == DRV_20 || c == DRV_30;
    endfunction

    // first sector uses the low half, last sector the high half
    function automatic logic [SUB_W:0] sub_of(input logic [IDX_W-1:0] i,
                                              input logic [63:0] a);
        return {i != '0, a[SUB_W:1]};
    endfunction

    // ----------------------------------------
    // command execution
    // ----------------------------------------
    assign go = s_q.req_s[2] ^ s_q.req_s[1];
    assign pin_rst = s_q.hold && !s_q.pin_s[1];
    assign pw_on = !s_q.prot[PROT_PW_BIT];
    assign wcfg = {arg[7:4], 1'b1,
                   drv_legal(arg[2:0]) ? arg[2:0] : s_q.cfg[2:0]};

    always_comb begin
        s_d = s_q;
        s_d.pin_s = {s_q.pin_s[0], data_line_three};
        s_d.req_s = {s_q.req_s[1:0], req_tog};
        if (go) begin
            s_d.ack = ~s_q.ack;
            s_d.ok = 1'b1;
            s_d.rsp = '0;
            unique case (op)
                CMD_WR_CFG: begin
                    s_d.cfg = wcfg;
                end
                CMD_RD_CFG: begin
                    s_d.rsp[7:0] = s_q.cfg;
                end
                CMD_RESCUE: begin
                    s_d.cfg = CFG_RESET;
                end
                CMD_RD_PROT: begin
                    s_d.rsp[15:0] = s_q.prot;
                end
                CMD_WR_PROT: begin
                    // bits only ever clear, and never both
                    if ((s_q.prot[2:1] & arg[2:1]) == 2'b00) begin
                        s_d.ok = 1'b0;
                    end else begin
                        s_d.prot[2:1] = s_q.prot[2:1] & arg[2:1];
                    end
                end
                CMD_RD_PW: begin
                    s_d.rsp = pw_on ? PW_HIDDEN : s_q.pw;
                end
                CMD_WR_PW: begin
                    if (pw_on) begin
                        s_d.ok = 1'b0;
                    end else begin
                        s_d.pw = arg;
                    end
                end
                CMD_RD_FRZ: begin
                    s_d.rsp[0] = s_q.frz; // upper bits read zero
                end
                CMD_WR_FRZ: begin
                    s_d.frz = 1'b0;
                end
                CMD_UNLOCK: begin
                    if (!pw_on || arg == s_q.pw) begin
                        s_d.frz = 1'b1;
                    end else begin
                        s_d.ok = 1'b0;
                    end
                end
                CMD_WR_NV: begin
                    if (s_q.frz) begin
                        s_d.nv[idx] = 1'b0;
                    end else begin
                        s_d.ok = 1'b0;
                    end
                end
                CMD_ER_NV: begin
                    if (s_q.frz) begin
                        s_d.nv = '1;
                    end else begin
                        s_d.ok = 1'b0;
                    end
                end
                CMD_RD_NV: begin
                    s_d.rsp[0] = s_q.nv[idx];
                end
                CMD_WR_VOL: begin
                    if (idx == '0 || idx == IDX_W'(SECTORS - 1)) begin
                        s_d.sub[sub_of(idx, arg)] = arg[0];
                    end else begin
                        s_d.vol[idx] = arg[0];
                    end
                end
                CMD_RD_VOL: begin
                    if (idx == '0 || idx == IDX_W'(SECTORS - 1)) begin
                        s_d.rsp[0] = s_q.sub[sub_of(idx, arg)];
                    end else begin
                        s_d.rsp[0] = s_q.vol[idx];
                    end
                end
                CMD_SW_RST: begin
                    s_d.cfg = CFG_RESET; // volatile part handled below
                end
            endcase
            // register download after a config read or write
            if (op == CMD_WR_CFG || op == CMD_RD_CFG || op == CMD_RESCUE) begin
                s_d.proto = proto_of(s_d.cfg);
                s_d.dtr = !s_d.cfg[CFG_DTR_BIT];
                s_d.hold = s_d.cfg[CFG_HOLD_BIT];
                s_d.drv = s_d.cfg[CFG_DRV_MSB:0];
            end
        end
        // volatile defaults on pin or software reset
        if (pin_rst || (go && op == CMD_SW_RST)) begin
            s_d.cfg = CFG_RESET;
            s_d.proto = PROTO_SINGLE;
            s_d.dtr = 1'b0;
            s_d.hold = 1'b1;
            s_d.drv = DRV_30;
            s_d.frz = s_q.prot[PROT_PW_BIT];
            s_d.vol = '0;
            s_d.sub = '0;
        end
        // power-on: everything to factory state
        if (rst) begin
            s_d = '0;
            s_d.cfg = CFG_RESET;
            s_d.proto = PROTO_SINGLE;
            s_d.hold = 1'b1;
            s_d.drv = DRV_30;
            s_d.prot = PROT_RESET;
            s_d.frz = 1'b1;
            s_d.pw = PW_RESET;
            s_d.nv = '1;
            // pin idles high; a zero here would fake a pin reset on release
            s_d.pin_s = 2'b11;
        end
        s_d.blk = ~s_d.nv | s_d.vol;
    end

    // one register stage for the whole reference-side state
    always_ff @(posedge ref_clk) begin
        s_q <= s_d;
    end

    // ----------------------------------------
    // link side and outputs
    // ----------------------------------------
    fcp_link #(.IDX_W(IDX_W)) u_link (
        .sclk(sclk),
        .rst(rst),
        .cmd_valid(cmd_valid),
        .cmd_op(cmd_op),
        .cmd_idx(cmd_idx),
        .cmd_arg(cmd_arg),
        .cmd_busy(cmd_busy),
        .rsp_valid(rsp_valid),
        .rsp_ok(rsp_ok),
        .rsp_data(rsp_data),
        .req_tog(req_tog),
        .held_op(op),
        .held_idx(idx),
        .held_arg(arg),
        .ack_tog(ack_tog),
        .ref_ok(s_q.ok),
        .ref_rsp(s_q.rsp)
    );

    assign ack_tog = s_q.ack;
    assign proto_mode = s_q.proto;
    assign dtr_en = s_q.dtr;
    assign hold_rst_en = s_q.hold;
    assign drive_code = s_q.drv;
    assign frz_bit = s_q.frz;
    assign pw_mode = !s_q.prot[PROT_PW_BIT];
    assign sector_blocked = s_q.blk;
    assign edge_sub_lock = s_q.sub;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    proto_prio_a: assert property (@(posedge ref_clk) disable iff (rst)
        (go && op == CMD_WR_CFG && !arg[7] && !pin_rst) |=> s_q.proto == PROTO_QUAD)
        else $error("four-line not selected");
    proto_dual_a: assert property (@(posedge ref_clk) disable iff (rst)
        (go && op == CMD_WR_CFG && arg[7] && !arg[6] && !pin_rst)
        |=> s_q.proto == PROTO_DUAL)
        else $error("two-line not selected");
    cfg_rsvd_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.cfg[CFG_RSVD_BIT] && s_q.prot[0] && s_q.prot[15:3] == 13'h1fff)
        else $error("reserved bit changed");
    otp_excl_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.prot[2] || s_q.prot[1])
        else $error("both mode bits cleared");
    otp_once_a: assert property (@(posedge ref_clk) disable iff (rst)
        !$rose(s_q.prot[2]) && !$rose(s_q.prot[1]))
        else $error("mode bit returned to one");
    pw_fixed_a: assert property (@(posedge ref_clk) disable iff (rst)
        $past(pw_on) |-> $stable(s_q.pw))
        else $error("password changed in password mode");
    frz_release_a: assert property (@(posedge ref_clk) disable iff (rst)
        ($rose(s_q.frz) && $past(pw_on))
        |-> $past(go && op == CMD_UNLOCK && arg == s_q.pw))
        else $error("freeze released without password");
    nv_frozen_a: assert property (@(posedge ref_clk) disable iff (rst)
        !s_q.frz |=> $stable(s_q.nv))
        else $error("lock bits changed while frozen");
    vol_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        pin_rst |=> s_q.vol == '0 && s_q.frz == !pw_on)
        else $error("volatile state not reset");
    blk_map_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.blk == (~s_q.nv | s_q.vol))
        else $error("sector block map wrong");
endmodule

`default_nettype wire

// ===== verification/fcp_host_model.sv
/*
 * host-side command issuer for the flash register block.
 * assumes one command at a time on the serial clock, offered at
 * a falling edge and answered by a one-cycle rsp_valid pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module fcp_host_model
    import fcp_pkg::*;
#(
    parameter int IDX_W = 3
) (
    input wire logic sclk,
    input wire logic cmd_busy,
    input wire logic rsp_valid,
    input wire logic rsp_ok,
    input wire logic [63:0] rsp_data,
    output logic cmd_valid,
    output fcp_cmd_type cmd_op,
    output logic [IDX_W-1:0] cmd_idx,
    output logic [63:0] cmd_arg
);
    // ----------------------------------------
    // idle state at time zero
    // ----------------------------------------
    initial begin
        cmd_valid = 1'b0;
        cmd_op = CMD_RD_CFG;
        cmd_idx = '0;
        cmd_arg = '0;
    end

    // ----------------------------------------
    // one command: offer, release, wait for answer
    // ----------------------------------------
    // index and argument are scrambled after release so a design that samples late sees junk
    task automatic issue(input fcp_cmd_type op, input logic [IDX_W-1:0] idx,
                         input logic [63:0] arg, input int gap, output logic ok,
                         output logic [63:0] data, output logic hung);
        int n;
        hung = 1'b1;
        ok = 1'b0;
        data = '0;
        repeat (gap + 1) @(negedge sclk);
        n = 0;
        while (cmd_busy !== 1'b0 && n < 100) begin // wait up to 100 cycles for busy to drop before offering
            @(negedge sclk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_idx = idx;
        cmd_arg = arg;
        @(negedge sclk); // the rising edge between took it
        cmd_valid = 1'b0;
        cmd_idx = ~idx;
        cmd_arg = ~arg;
        for (n = 0; n < 100 && hung; n++) begin // bounded wait for the answer
            if (rsp_valid === 1'b1) begin
                ok = rsp_ok;
                data = rsp_data;
                hung = 1'b0;
            end else begin
                @(negedge sclk);
            end
        end
    endtask
endmodule

`default_nettype wire

// ===== verification/fcp_regs_tb.sv
/*
 * self-checking bench for the configuration and protection registers.
 * assumes the host model file and the register package are compiled
 * first; uses 8 sectors with 4 edge subsectors to keep vectors short.
 */
`timescale 1ns/1ps
`default_nettype none

module fcp_regs_tb;
    import fcp_pkg::*;
    // ----------------------------------------
    // sizes, stimulus tables and wiring
    // ----------------------------------------
    localparam int SEC = 8; // sectors in this run
    localparam int SUB = 4; // subsectors per edge sector
    localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef; // test password
    localparam logic [7:0] WTAB [11] = '{8'h7f, 8'hbf, 8'h3f, 8'hdf, 8'hef, 8'hf9,
                                        8'hfb, 8'hfd, 8'hf2, 8'h77, 8'hff};
    logic ref_clk, sclk, rst, pin3;
    logic cmd_valid, cmd_busy, rsp_valid, rsp_ok, ok, hung;
    fcp_cmd_type cmd_op;
    logic [2:0] cmd_idx;
    logic [63:0] cmd_arg, rsp_data, rd;
    fcp_proto_type proto_mode;
    logic dtr_en, hold_rst_en, frz_bit, pw_mode;
    logic [2:0] drive_code;
    logic [SEC-1:0] sector_blocked;
    logic [2*SUB-1:0] edge_sub_lock;
    logic [7:0] cfg; // expected configuration value
    int fails, n_checks, cycles;

    fcp_regs #(.SECTORS(SEC), .SUBS(SUB)) dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
        .data_line_three(pin3), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_idx(cmd_idx),
        .cmd_arg(cmd_arg), .cmd_busy(cmd_busy), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
        .rsp_data(rsp_data), .proto_mode(proto_mode), .dtr_en(dtr_en),
        .hold_rst_en(hold_rst_en), .drive_code(drive_code), .frz_bit(frz_bit),
        .pw_mode(pw_mode), .sector_blocked(sector_blocked), .edge_sub_lock(edge_sub_lock));

    fcp_host_model #(.IDX_W(3)) host (.sclk(sclk), .cmd_busy(cmd_busy),
        .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_data(rsp_data), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_idx(cmd_idx), .cmd_arg(cmd_arg));

    // ----------------------------------------
    // clocks: 40 MHz register clock, 6 ns link clock off phase
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        sclk = 1'b0;
        #1.7;
        forever #3 sclk = ~sclk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic final_report();
        if (fails == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // run one command and compare its accept flag
    task automatic run(input fcp_cmd_type op, input logic [2:0] idx, input logic [63:0] arg,
                       input logic exp_ok);
        host.issue(op, idx, arg, 1, ok, rd, hung);
        chk({63'h0, hung}, 64'h0, "no answer");
        chk({63'h0, ok}, {63'h0, exp_ok}, op.name());
        @(negedge ref_clk); // register-side outputs sampled off their edge
    endtask

    task automatic rd_chk(input fcp_cmd_type op, input logic [2:0] idx,
                          input logic [63:0] mask, input logic [63:0] exp);
        run(op, idx, 64'h0, 1'b1);
        chk(rd & mask, exp, "read data");
    endtask

    // read the config back and compare the active settings it implies
    task automatic chk_cfg(input logic [7:0] v);
        fcp_proto_type p;
        p = !v[7] ? PROTO_QUAD : (!v[6] ? PROTO_DUAL : PROTO_SINGLE);
        rd_chk(CMD_RD_CFG, 3'h0, 64'hff, {56'h0, v});
        chk({57'h0, proto_mode, dtr_en, hold_rst_en, drive_code},
            {57'h0, p, ~v[5], v[4], v[2:0]}, "active settings");
    endtask

    // bit 3 always reads one; an even drive code is reserved, old code kept
    function automatic logic [7:0] next_cfg(input logic [7:0] old, input logic [7:0] w);
        logic [7:0] n;
        n = w | 8'h08;
        if (!w[0]) begin
            n[2:0] = old[2:0];
        end
        return n;
    endfunction

    task automatic do_reset();
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        repeat (10) @(negedge ref_clk);
    endtask

    // pin reset: hold the pin low long enough to pass its synchroniser
    task automatic pin_pulse();
        @(negedge ref_clk);
        pin3 = 1'b0;
        repeat (8) @(negedge ref_clk);
        pin3 = 1'b1;
        repeat (8) @(negedge ref_clk);
    endtask

    // ----------------------------------------
    // hang guard
    // ----------------------------------------
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            $display("ERROR t=%0t run did not finish", $time);
            final_report();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        pin3 = 1'b1;
        fails = 0;
        n_checks = 0;
        cycles = 0;
        do_reset();
        // reset values of all three registers and the locks
        cfg = 8'hff;
        chk_cfg(cfg);
        rd_chk(CMD_RD_PROT, 3'h0, 64'hffff, 64'hffff);
        rd_chk(CMD_RD_FRZ, 3'h0, 64'h1, 64'h1);
        chk({sector_blocked, edge_sub_lock}, 64'h0, "locks after reset");
        // every protocol, rate, pin and drive setting, plus reserved drive code 2
        foreach (WTAB[i]) begin
            run(CMD_WR_CFG, 3'h0, {56'h0, WTAB[i]}, 1'b1);
            cfg = next_cfg(cfg, WTAB[i]);
            chk_cfg(cfg);
        end
        // rescue, soft reset and, with the hold bit set, pin reset restore defaults
        run(CMD_WR_CFG, 3'h0, 64'h7f, 1'b1);
        run(CMD_RESCUE, 3'h0, 64'h0, 1'b1);
        chk_cfg(8'hff);
        run(CMD_WR_CFG, 3'h0, 64'h1b, 1'b1);
        run(CMD_SW_RST, 3'h0, 64'h0, 1'b1);
        chk_cfg(8'hff);
        run(CMD_WR_CFG, 3'h0, 64'h3f, 1'b1);
        pin_pulse();
        chk_cfg(8'hff);
        run(CMD_WR_CFG, 3'h0, 64'he9, 1'b1);
        pin_pulse();
        chk_cfg(8'he9);
        run(CMD_WR_CFG, 3'h0, 64'hff, 1'b1);
        // nonvolatile and volatile locks, edge subsectors
        run(CMD_WR_NV, 3'h2, 64'h0, 1'b1);
        chk(sector_blocked, 64'h04, "nv lock");
        rd_chk(CMD_RD_NV, 3'h2, 64'h1, 64'h0);
        rd_chk(CMD_RD_NV, 3'h3, 64'h1, 64'h1);
        run(CMD_WR_VOL, 3'h3, 64'h1, 1'b1);
        chk(sector_blocked, 64'h0c, "vol lock");
        run(CMD_WR_VOL, 3'h0, 64'h5, 1'b1);
        run(CMD_WR_VOL, 3'h7, 64'h3, 1'b1);
        chk(edge_sub_lock, 64'h24, "subsector locks");
        run(CMD_SW_RST, 3'h0, 64'h0, 1'b1);
        chk({sector_blocked, edge_sub_lock}, 64'h0400, "locks after sw reset");
        // freeze guards the nonvolatile bits once they are set
        run(CMD_WR_FRZ, 3'h0, 64'h0, 1'b1);
        chk(frz_bit, 64'h0, "freeze cleared");
        run(CMD_WR_NV, 3'h4, 64'h0, 1'b0);
        run(CMD_ER_NV, 3'h0, 64'h0, 1'b0);
        chk(sector_blocked, 64'h04, "frozen locks");
        run(CMD_UNLOCK, 3'h0, 64'h0, 1'b1);
        chk(frz_bit, 64'h1, "unfrozen");
        run(CMD_ER_NV, 3'h0, 64'h0, 1'b1);
        chk(sector_blocked, 64'h0, "nv erased");
        // password mode: password first, then the one-time bit
        run(CMD_WR_PW, 3'h0, PW, 1'b1);
        rd_chk(CMD_RD_PW, 3'h0, '1, PW);
        run(CMD_WR_PROT, 3'h0, 64'h0, 1'b0);
        run(CMD_WR_PROT, 3'h0, 64'h2, 1'b1);
        rd_chk(CMD_RD_PROT, 3'h0, 64'hffff, 64'hfffb);
        chk(pw_mode, 64'h1, "password mode");
        run(CMD_WR_PROT, 3'h0, 64'h4, 1'b0);
        run(CMD_WR_PW, 3'h0, 64'h0, 1'b0);
        rd_chk(CMD_RD_PW, 3'h0, '1, '1);
        run(CMD_SW_RST, 3'h0, 64'h0, 1'b1);
        chk(frz_bit, 64'h0, "freeze after reset");
        run(CMD_WR_NV, 3'h1, 64'h0, 1'b0);
        run(CMD_UNLOCK, 3'h0, ~PW, 1'b0);
        chk(frz_bit, 64'h0, "wrong password");
        run(CMD_UNLOCK, 3'h0, PW, 1'b1);
        chk(frz_bit, 64'h1, "right password");
        run(CMD_WR_NV, 3'h1, 64'h0, 1'b1);
        chk(sector_blocked, 64'h02, "lock after unlock");
        run(CMD_WR_FRZ, 3'h0, 64'h0, 1'b1);
        // power-on, then the no-password mode
        do_reset();
        run(CMD_WR_PROT, 3'h0, 64'h4, 1'b1);
        rd_chk(CMD_RD_PROT, 3'h0, 64'hffff, 64'hfffd);
        run(CMD_WR_PROT, 3'h0, 64'h2, 1'b0);
        chk(pw_mode, 64'h0, "no password mode");
        run(CMD_WR_NV, 3'h5, 64'h0, 1'b1);
        chk(sector_blocked, 64'h20, "lock in no password mode");
        final_report();
    end
endmodule

`default_nettype wire
